// ### design/sum_pkg.sv
// Shared constants and carrier types for the user-side layer 1 maintenance block.
// Assumes a 200 MHz system clock and byte-wide overhead strobes from the framer.
package sum_pkg;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned MS_PS         = 1000000000;
  localparam int unsigned CYC_PER_MS    = MS_PS / CLK_PERIOD_PS;
  localparam int unsigned LOF_DEF       = 4;
  localparam int unsigned AIS_DELAY_NS  = 1000;
  localparam int unsigned AIS_DELAY_CYC = (AIS_DELAY_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned K2_LSB        = 0;
  localparam logic [2:0]  K2_AIS_CODE   = 3'h7;
  localparam logic [2:0]  K2_RDI_CODE   = 3'h6;
  localparam int unsigned G1_RDI_BIT    = 3;
  localparam logic [7:0]  ALL_ONES      = 8'hff;

  typedef enum logic [1:0] {DL_HUNT, DL_PRESYNC, DL_SYNC} sum_delin_t;

  typedef enum logic [2:0] {
    user_power_off_state, user_operational_state, user_fault_upstream_access,
    user_fault_downstream_iface, user_fault_downstream_access,
    user_fault_upstream_iface, user_fault_combined, user_power_on_state
  } sum_fstate_t;

  typedef struct packed {
    logic       frameOk;
    logic       frameStb;
    logic       ptrValid;
    logic       ptrStb;
    logic       k2Stb;
    logic [7:0] k2;
    logic       g1Stb;
    logic [7:0] g1;
    logic       pAis;
  } sum_rx_t;

  typedef struct packed {
    logic       sendSignal;
    logic       pAisIns;
    logic [2:0] k2Bits;
    logic       g1Rdi;
  } sum_tx_t;

  typedef struct packed {
    logic [2:0]  losSync;
    logic        losQ;
    logic [7:0]  lofCnt;
    logic        lof;
    logic        lop;
    logic        msAis;
    logic        msRdiRx;
    logic        pRdiRx;
    sum_delin_t  delinPrev;
    logic        ocd;
    logic        lcd;
    logic [31:0] ocdCnt;
    logic [31:0] syncCnt;
    logic [15:0] aisCnt;
    sum_fstate_t fState;
    sum_tx_t     tx;
  } sum_state_t;
endpackage

// ### design/sum_maint.sv
// User-side layer 1 maintenance: defect detection, F-state tracking, AIS/RDI insertion.
// Assumes framer strobes on mclk; loss of signal arrives asynchronously from the line receiver.
`timescale 1ns/1ps
module sum_maint
  import sum_pkg::*;
#(
  parameter int unsigned LCD_MS = 0
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        powerGood,
  input  wire logic        losIn,
  input  wire logic [7:0]  lofLimit,
  input  wire sum_rx_t     rx,
  input  wire sum_delin_t  delinState,
  output      sum_tx_t     tx,
  output      logic        lofOut,
  output      logic        lopOut,
  output      logic        msAisOut,
  output      logic        ocdOut,
  output      logic        lcdOut,
  output      sum_fstate_t fStateOut
);

  localparam logic [31:0] LCD_CYC = 32'(LCD_MS * CYC_PER_MS);

  sum_state_t cur;
  sum_state_t next_cur;

  function automatic logic [31:0] satInc(input logic [31:0] v);
    return (v == 32'hffffffff) ? v : v + 32'h1;
  endfunction

  logic los;
  logic defSec;
  logic defPath;

  assign los     = cur.losQ;
  assign defSec  = los | cur.lof | cur.msAis;
  assign defPath = defSec | cur.lop | cur.lcd | rx.pAis;

  always_comb begin
    next_cur = cur;
    // LOS filter: change counts once stages 2 and 3 agree
    next_cur.losSync = {cur.losSync[1:0], losIn};
    if (cur.losSync[2] == cur.losSync[1]) begin
      next_cur.losQ = cur.losSync[2];
    end
    if (rx.frameStb) begin
      if (rx.frameOk) begin
        next_cur.lofCnt = 8'h0;
        next_cur.lof    = 1'b0;
      end else begin
        if (cur.lofCnt != 8'hff) begin
          next_cur.lofCnt = cur.lofCnt + 8'h1;
        end
        if (cur.lofCnt + 8'h1 >= lofLimit) begin
          next_cur.lof = 1'b1;
        end
      end
    end
    if (rx.ptrStb) begin
      next_cur.lop = ~rx.ptrValid;
    end
    // K2 AIS detect and far-end RDI capture
    if (rx.k2Stb) begin
      next_cur.msAis   = (rx.k2[K2_LSB +: 3] == K2_AIS_CODE);
      next_cur.msRdiRx = (rx.k2[K2_LSB +: 3] == K2_RDI_CODE);
    end
    if (rx.g1Stb) begin
      next_cur.pRdiRx = rx.g1[G1_RDI_BIT];
    end
    // Cell delineation anomaly and defect
    next_cur.delinPrev = delinState;
    if (cur.delinPrev == DL_SYNC && delinState == DL_HUNT) begin
      next_cur.ocd = 1'b1;
    end
    if (cur.delinPrev == DL_PRESYNC && delinState == DL_SYNC) begin
      next_cur.ocd = 1'b0;
    end
    if (cur.ocd && !cur.lcd) begin
      next_cur.ocdCnt = satInc(cur.ocdCnt);
      if (cur.ocdCnt >= LCD_CYC) begin
        next_cur.lcd = 1'b1;
        next_cur.ocd = 1'b0;
      end
    end else begin
      next_cur.ocdCnt = 32'h0;
    end
    if (delinState == DL_SYNC) begin
      next_cur.syncCnt = satInc(cur.syncCnt);
      if (cur.lcd && cur.syncCnt >= LCD_CYC) begin
        next_cur.lcd = 1'b0;
      end
    end else begin
      next_cur.syncCnt = 32'h0;
    end
    if (defSec | cur.lop) begin
      if (cur.aisCnt < 16'(AIS_DELAY_CYC)) begin
        next_cur.aisCnt = cur.aisCnt + 16'h1;
      end
    end else begin
      next_cur.aisCnt = 16'h0;
    end
    // User-side F-state machine
    if (!powerGood) begin
      next_cur.fState = user_power_off_state;
    end else begin
      unique case (cur.fState)
        user_power_off_state: next_cur.fState = user_power_on_state;
        user_operational_state, user_fault_upstream_access,
        user_fault_downstream_iface, user_fault_downstream_access,
        user_fault_upstream_iface, user_fault_combined,
        user_power_on_state: begin
          if (los | cur.lof) begin
            next_cur.fState = user_fault_downstream_iface;
          end else if ((rx.pAis | cur.lop | (cur.lcd & cur.pRdiRx)) && cur.msRdiRx) begin
            next_cur.fState = user_fault_combined;
          end else if (rx.pAis | cur.lop | cur.lcd | cur.msAis) begin
            next_cur.fState = user_fault_downstream_access;
          end else if (cur.msRdiRx && cur.pRdiRx) begin
            next_cur.fState = user_fault_upstream_iface;
          end else if (cur.pRdiRx) begin
            next_cur.fState = user_fault_upstream_access;
          end else begin
            next_cur.fState = user_operational_state;
          end
        end
      endcase
    end
    // Outgoing overhead per state
    next_cur.tx = '0;
    // signal only when powered and evaluated
    next_cur.tx.sendSignal = (next_cur.fState != user_power_off_state) &&
                             (next_cur.fState != user_power_on_state);
    next_cur.tx.pAisIns = next_cur.tx.sendSignal && (next_cur.aisCnt >= 16'(AIS_DELAY_CYC));
    if (next_cur.tx.sendSignal && (los | cur.lof | cur.msAis)) begin
      next_cur.tx.k2Bits = K2_RDI_CODE;
    end
    next_cur.tx.g1Rdi = next_cur.tx.sendSignal && (defPath ||
                        next_cur.fState == user_fault_combined ||
                        next_cur.fState == user_fault_downstream_access ||
                        next_cur.fState == user_fault_downstream_iface);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cur        <= '0;
      cur.fState <= user_power_off_state;
    end else begin
      cur <= next_cur;
    end
  end

  assign tx        = cur.tx;
  assign lofOut    = cur.lof;
  assign lopOut    = cur.lop;
  assign msAisOut  = cur.msAis;
  assign ocdOut    = cur.ocd;
  assign lcdOut    = cur.lcd;
  assign fStateOut = cur.fState;

  a_k2_ais_det: assert property (@(posedge mclk) disable iff (sys_rst)
    rx.k2Stb && rx.k2[2:0] == 3'h7 |=> msAisOut)
    else $error("k2 ais not detected");
  a_lop_det: assert property (@(posedge mclk) disable iff (sys_rst)
    rx.ptrStb && !rx.ptrValid |=> lopOut)
    else $error("lop not raised");
  a_lof_clear: assert property (@(posedge mclk) disable iff (sys_rst)
    rx.frameStb && rx.frameOk |=> !lofOut)
    else $error("lof not cleared");
  a_msrdi_send: assert property (@(posedge mclk) disable iff (sys_rst)
    lofOut && powerGood && tx.sendSignal |=> (tx.k2Bits == 3'h6 || !tx.sendSignal))
    else $error("ms-rdi code missing");
  a_prdi_lop: assert property (@(posedge mclk) disable iff (sys_rst)
    lopOut && tx.sendSignal && $stable(lopOut) |=> tx.g1Rdi || !tx.sendSignal)
    else $error("p-rdi missing");
  a_ocd_entry: assert property (@(posedge mclk) disable iff (sys_rst)
    $past(delinState) == DL_SYNC && delinState == DL_HUNT && !lcdOut |=> ocdOut || lcdOut)
    else $error("ocd not entered");
  a_los_fault: assert property (@(posedge mclk) disable iff (sys_rst)
    powerGood && $past(powerGood) && cur.losQ && fStateOut != user_power_off_state
    |=> fStateOut == user_fault_downstream_iface)
    else $error("los did not give fault two");
  a_power_off: assert property (@(posedge mclk) disable iff (sys_rst)
    !powerGood |=> fStateOut == user_power_off_state ##1 !tx.sendSignal)
    else $error("power off not silent");
  a_power_on: assert property (@(posedge mclk) disable iff (sys_rst)
    fStateOut == user_power_off_state && powerGood |=> fStateOut == user_power_on_state)
    else $error("power on skipped");

  // Defect detection
  a_lof_set: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(lofOut) |-> $past(rx.frameStb) && !$past(rx.frameOk))
    else $error("lof raised without errored frame");
  a_lop_clear: assert property (@(posedge mclk) disable iff (sys_rst)
    rx.ptrStb && rx.ptrValid |=> !lopOut)
    else $error("lop not cleared");
  a_k2_ais_clear: assert property (@(posedge mclk) disable iff (sys_rst)
    rx.k2Stb && rx.k2[2:0] != 3'h7 |=> !msAisOut)
    else $error("ms-ais not cleared");
  a_los_filter: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(cur.losQ) |-> $past(cur.losSync[2]) && $past(cur.losSync[1]))
    else $error("los accepted before filter agreed");

  // Alarm insertion
  a_pais_cause: assert property (@(posedge mclk) disable iff (sys_rst)
    !(cur.losQ || lofOut || msAisOut || lopOut) |=> !tx.pAisIns)
    else $error("p-ais without cause");
  a_pais_gate: assert property (@(posedge mclk) disable iff (sys_rst)
    tx.pAisIns |-> tx.sendSignal)
    else $error("p-ais while silent");
  a_prdi_pais: assert property (@(posedge mclk) disable iff (sys_rst)
    rx.pAis && powerGood && fStateOut != user_power_off_state |=> tx.g1Rdi)
    else $error("p-rdi missing on p-ais");

  // Cell delineation
  a_lcd_entry: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(lcdOut) |-> $past(ocdOut))
    else $error("lcd without ocd");
  a_ocd_end: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(lcdOut) |-> !ocdOut)
    else $error("ocd kept after lcd entry");
  a_lcd_exit: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(lcdOut) |-> $past(delinState) == DL_SYNC)
    else $error("lcd cleared outside sync");
  a_lcd_zero: assert property (@(posedge mclk) disable iff (sys_rst)
    LCD_MS == 0 && ocdOut && !lcdOut |=> lcdOut)
    else $error("lcd late with zero x");

  // F-state entry
  a_lof_fault: assert property (@(posedge mclk) disable iff (sys_rst)
    powerGood && lofOut && fStateOut != user_power_off_state
    |=> fStateOut == user_fault_downstream_iface)
    else $error("lof did not give fault two");
  a_ds_access: assert property (@(posedge mclk) disable iff (sys_rst)
    powerGood && fStateOut != user_power_off_state && !cur.losQ && !lofOut &&
    (lopOut || lcdOut) && !cur.msRdiRx |=> fStateOut == user_fault_downstream_access)
    else $error("path defect did not give fault three");
  a_comb_entry: assert property (@(posedge mclk) disable iff (sys_rst)
    powerGood && fStateOut != user_power_off_state && !cur.losQ && !lofOut &&
    lopOut && cur.msRdiRx |=> fStateOut == user_fault_combined)
    else $error("lop with ms-rdi did not give combined fault");
  a_pon_leave: assert property (@(posedge mclk) disable iff (sys_rst)
    fStateOut == user_power_on_state && powerGood |=> fStateOut != user_power_on_state)
    else $error("power on not transient");

  // Outgoing overhead by state
  a_op_tx: assert property (@(posedge mclk) disable iff (sys_rst)
    fStateOut == user_operational_state |-> tx.sendSignal && !tx.g1Rdi && tx.k2Bits == 3'h0)
    else $error("operational frames not clean");
  a_us_access_tx: assert property (@(posedge mclk) disable iff (sys_rst)
    fStateOut == user_fault_upstream_access |-> tx.sendSignal && !tx.g1Rdi && tx.k2Bits == 3'h0)
    else $error("fault one frames not operational");
  a_fault_two_tx: assert property (@(posedge mclk) disable iff (sys_rst)
    fStateOut == user_fault_downstream_iface |-> tx.k2Bits == K2_RDI_CODE && tx.g1Rdi)
    else $error("fault two frames lack rdi");
  a_fault_three_tx: assert property (@(posedge mclk) disable iff (sys_rst)
    fStateOut == user_fault_downstream_access |-> tx.g1Rdi)
    else $error("fault three frames lack p-rdi");
  a_us_iface_tx: assert property (@(posedge mclk) disable iff (sys_rst)
    fStateOut == user_fault_upstream_iface |-> tx.sendSignal && !tx.g1Rdi && tx.k2Bits == 3'h0)
    else $error("fault four frames not operational");
  a_comb_tx: assert property (@(posedge mclk) disable iff (sys_rst)
    fStateOut == user_fault_combined |-> tx.g1Rdi)
    else $error("combined fault frames lack p-rdi");
  a_silent_tx: assert property (@(posedge mclk) disable iff (sys_rst)
    fStateOut == user_power_off_state || fStateOut == user_power_on_state
    |-> !tx.sendSignal && !tx.pAisIns && !tx.g1Rdi && tx.k2Bits == 3'h0)
    else $error("overhead sent while silent");

  c_lof: cover property (@(posedge mclk) lofOut);
  c_lcd: cover property (@(posedge mclk) lcdOut);
  c_comb: cover property (@(posedge mclk) fStateOut == user_fault_combined);
  c_ais: cover property (@(posedge mclk) tx.pAisIns);
  c_pwr_on: cover property (@(posedge mclk) fStateOut == user_power_on_state);

endmodule

// ### dv/sum_net_model.sv
// Network-side model: sends one frame's overhead strobes every 8 mclk cycles.
// Assumes mode is set by the bench; frameOk, ptrValid, k2 and g1 invert every cycle between strobes, pAis follows mode each cycle.
`timescale 1ns/1ps
module sum_net_model
  import sum_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic [2:0] mode,
  output      sum_rx_t    rx
);
  logic [2:0] cnt = 3'h0;
  logic       stb;
  logic [7:0] k2v;
  logic [7:0] g1v;
  initial rx = '0;
  assign stb = (cnt == 3'h7);
  assign k2v = (mode == 3'h3) ? 8'h07 : (mode == 3'h2) ? 8'h06 : 8'h00;
  assign g1v = (mode == 3'h1 || mode == 3'h2) ? 8'h08 : 8'h00;
  always @(posedge mclk) begin
    cnt         <= #1 cnt + 3'h1;
    rx.frameStb <= #1 stb;
    rx.ptrStb   <= #1 stb;
    rx.k2Stb    <= #1 stb;
    rx.g1Stb    <= #1 stb;
    rx.frameOk  <= #1 stb ? (mode != 3'h4) : ~rx.frameOk;
    rx.ptrValid <= #1 stb ? (mode != 3'h5) : ~rx.ptrValid;
    rx.k2       <= #1 stb ? k2v : ~rx.k2;
    rx.g1       <= #1 stb ? g1v : ~rx.g1;
    rx.pAis     <= #1 (mode == 3'h6);
  end
endmodule

// ### dv/tb.sv
// Self-checking bench for the user-side maintenance block.
// Assumes the network model strobes a frame every 8 cycles; LCD_MS is 0.
`timescale 1ns/1ps
module tb;
  import sum_pkg::*;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        powerGood = 1'b0;
  logic        losIn = 1'b0;
  logic [7:0]  lofLimit = 8'h03;
  logic [2:0]  mode = 3'h0;
  sum_delin_t  delinState = DL_SYNC;
  sum_rx_t     rx;
  sum_tx_t     tx;
  logic        lofOut, lopOut, msAisOut, ocdOut, lcdOut, seen;
  sum_fstate_t fStateOut;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  always #2.5 mclk = ~mclk;
  sum_net_model net (.mclk(mclk), .mode(mode), .rx(rx));
  sum_maint #(.LCD_MS(0)) uut (
    .mclk(mclk), .sys_rst(sys_rst), .powerGood(powerGood), .losIn(losIn),
    .lofLimit(lofLimit), .rx(rx), .delinState(delinState), .tx(tx),
    .lofOut(lofOut), .lopOut(lopOut), .msAisOut(msAisOut), .ocdOut(ocdOut),
    .lcdOut(lcdOut), .fStateOut(fStateOut));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic frames(input int n);
    repeat (n) @(posedge mclk iff rx.frameStb);
    #1;
  endtask
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_power;
    chk(fStateOut, user_power_off_state);
    chk(tx.sendSignal, 1'b0);
    powerGood = 1'b1;
    seen = 1'b0;
    repeat (4) begin
      cyc(1);
      if (fStateOut === user_power_on_state) seen = 1'b1;
    end
    chk(seen, 1'b1);
    frames(2);
    cyc(4);
    chk(fStateOut, user_operational_state);
    chk(tx.sendSignal, 1'b1);
    chk(tx.g1Rdi, 1'b0);
  endtask
  task automatic t_lof;
    mode = 3'h4;
    frames(2);
    cyc(4);
    chk(lofOut, 1'b0);
    frames(1);
    cyc(4);
    chk(lofOut, 1'b1);
    chk(fStateOut, user_fault_downstream_iface);
    chk(tx.k2Bits, K2_RDI_CODE);
    chk(tx.g1Rdi, 1'b1);
    mode = 3'h0;
    frames(1);
    cyc(4);
    chk(lofOut, 1'b0);
  endtask
  task automatic t_msais;
    mode = 3'h3;
    frames(1);
    cyc(4);
    chk(msAisOut, 1'b1);
    chk(tx.k2Bits, K2_RDI_CODE);
    chk(tx.g1Rdi, 1'b1);
    chk(tx.pAisIns, 1'b0);
    cyc(AIS_DELAY_CYC);
    chk(tx.pAisIns, 1'b1);
    mode = 3'h5;
    frames(2);
    cyc(4);
    chk(msAisOut, 1'b0);
    chk(lopOut, 1'b1);
    chk(fStateOut, user_fault_downstream_access);
    chk(tx.g1Rdi, 1'b1);
  endtask
  task automatic t_remote;
    mode = 3'h1;
    frames(2);
    cyc(4);
    chk(lopOut, 1'b0);
    chk(fStateOut, user_fault_upstream_access);
    chk(tx.g1Rdi, 1'b0);
    mode = 3'h2;
    frames(1);
    cyc(4);
    chk(fStateOut, user_fault_upstream_iface);
    chk(tx.sendSignal, 1'b1);
    delinState = DL_HUNT;
    cyc(1);
    chk(ocdOut, 1'b1);
    cyc(3);
    chk(ocdOut, 1'b0);
    chk(lcdOut, 1'b1);
    chk(fStateOut, user_fault_combined);
    chk(tx.g1Rdi, 1'b1);
    mode = 3'h0;
    delinState = DL_PRESYNC;
    cyc(3);
    delinState = DL_SYNC;
    cyc(4);
    chk(ocdOut, 1'b0);
    chk(lcdOut, 1'b0);
  endtask
  task automatic t_pais;
    mode = 3'h6;
    cyc(4);
    chk(fStateOut, user_fault_downstream_access);
    chk(tx.g1Rdi, 1'b1);
    chk(tx.sendSignal, 1'b1);
    mode = 3'h0;
    cyc(4);
    chk(fStateOut, user_operational_state);
    chk(tx.g1Rdi, 1'b0);
  endtask
  task automatic t_los_off;
    losIn = 1'b1;
    cyc(10);
    chk(fStateOut, user_fault_downstream_iface);
    chk(tx.k2Bits, K2_RDI_CODE);
    powerGood = 1'b0;
    cyc(4);
    chk(fStateOut, user_power_off_state);
    chk(tx.sendSignal, 1'b0);
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (12) @(posedge mclk);
    #1 sys_rst = 1'b0;
    cyc(1);
    t_power();
    t_lof();
    t_msais();
    t_remote();
    t_pais();
    t_los_off();
    report_and_stop();
  end
endmodule
